// file: verilog/pd_map.svh
// Behaviour
// - Standby while deselected and not busy
// - Deep state ignores all but resume
// - Opcode B9h then deselect enters deep
// - Bytes after the opcode byte ignored
// - Short or misaligned entry aborts to standby
// - Power-up lands in standby
// - Deep entry dropped while program busy
// - Opcode ABh then deselect resumes standby
// - Short or misaligned resume stays deep
// - Ultra entry discards both buffers
// - Ultra state ignores every command
// - Opcode 79h then deselect enters ultra
// - Ultra entry dropped while program busy
// - Dummy byte in exit pulse ignored
// - Exit within max time, early frames void
`ifndef PD_MAP_SVH
`define PD_MAP_SVH
// Opcodes
`define PD_OP_DEEP 8'hb9
`define PD_OP_RESUME 8'hab
`define PD_OP_ULTRA 8'h79
// Clock period and maximum state change times
`define PD_CLK_NS 40
`define PD_DEEP_ENTRY_MAX_NS 3000
`define PD_DEEP_RESUME_MAX_NS 35000
`define PD_ULTRA_ENTRY_MAX_NS 3000
`define PD_ULTRA_EXIT_MAX_NS 100000
// Pin to status latency: two synchroniser flops, state flop, status flop
`define PD_PIN_LAT 4
// Timer width and bits per opcode
`define PD_TMR_W 12
`define PD_OP_BITS 8
`endif

// file: verilog/pd_pkg.sv
`default_nettype none
package pd_pkg;
   // Power state machine
   typedef enum logic [2:0] {
      ST_STANDBY = 3'b000,
      ST_DEEP_ENTRY = 3'b001,
      ST_DEEP = 3'b010,
      ST_RESUME = 3'b011,
      ST_ULTRA_ENTRY = 3'b100,
      ST_ULTRA = 3'b101,
      ST_ULTRA_EXIT = 3'b110
   } pd_state_e;
   // Power status seen by the rest of the device
   typedef struct packed {
      logic standby;
      logic deep;
      logic ultra;
      logic cmd_ok;
   } pd_status_s;
   // Raw serial pins
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
   } pd_pins_s;
endpackage : pd_pkg
`default_nettype wire

// file: verilog/spi_flash_power_down_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "pd_map.svh"
module spi_flash_power_down_control
   import pd_pkg::*;
#(
   parameter int TMR_W = `PD_TMR_W
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic busy,
   output pd_status_s status,
   output logic buf_discard
);

   ////////////////////////////////////////////////////////////
   // Timing counts
   // Longest times round down, never below one cycle; the pin latency comes
   // out of the budget so the time from the select pin stays inside the maximum
   function automatic int cyc_of(input int ns);
      int c;
      c = ns / `PD_CLK_NS - `PD_PIN_LAT;
      return (c < 1) ? 1 : c;
   endfunction : cyc_of

   localparam int DEEP_CYC = cyc_of(`PD_DEEP_ENTRY_MAX_NS);
   localparam int RES_CYC = cyc_of(`PD_DEEP_RESUME_MAX_NS);
   localparam int ULE_CYC = cyc_of(`PD_ULTRA_ENTRY_MAX_NS);
   localparam int ULX_CYC = cyc_of(`PD_ULTRA_EXIT_MAX_NS);
   // Assertion windows: timer plus decode slack
   localparam int DEEP_WIN = DEEP_CYC + 2;
   localparam int RES_WIN = RES_CYC + 2;
   localparam int ULE_WIN = ULE_CYC + 2;
   localparam int ULX_WIN = ULX_CYC + 2;

   ////////////////////////////////////////////////////////////
   // Pin synchronisers
   pd_pins_s meta_r; // First stage, read only by sync_r
   pd_pins_s sync_r; // Second stage
   pd_pins_s last_r; // Previous sample for edges

   // Two flops per pin, then one more for edge finding
   always_ff @(posedge clock) begin
      if (!nrst) begin
         meta_r <= 3'b100;
         sync_r <= 3'b100;
         last_r <= 3'b100;
      end else begin
         meta_r <= '{cs_n: cs_n, sck: sck, si: si};
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   logic cs_fall; // Select asserted
   logic cs_rise; // Select released
   logic sck_rise; // Sample point of the opcode
   assign cs_fall = last_r.cs_n & ~sync_r.cs_n;
   assign cs_rise = ~last_r.cs_n & sync_r.cs_n;
   assign sck_rise = ~last_r.sck & sync_r.sck & ~sync_r.cs_n;

   ////////////////////////////////////////////////////////////
   // Opcode shifter
   logic [`PD_OP_BITS-1:0] op_r; // First byte of the frame
   logic [2:0] bits_r; // Bit count modulo eight
   logic byte_r; // A whole byte has arrived

   // MSB first; shifting stops after the first byte
   always_ff @(posedge clock) begin
      if (!nrst) begin
         op_r <= 8'h00;
         bits_r <= 3'h0;
         byte_r <= 1'b0;
      end else if (cs_fall) begin
         // New frame starts clean
         bits_r <= 3'h0;
         byte_r <= 1'b0;
      end else if (sck_rise) begin
         bits_r <= bits_r + 3'h1;
         if (!byte_r) begin
            op_r <= {op_r[6:0], sync_r.si};
         end
         if (bits_r == 3'h7) begin
            byte_r <= 1'b1;
         end
      end
   end

   // Whole opcode, released on a byte boundary; later bytes ignored.
   // Shifter state goes in as arguments so the assigns below follow it
   function automatic logic good_cmd(
      input logic [7:0] op, // Captured first byte
      input logic [2:0] bits, // Bit count modulo eight
      input logic whole, // First byte complete
      input logic [7:0] code // Opcode looked for
   );
      return whole && (bits == 3'h0) && (op == code);
   endfunction : good_cmd

   logic hit_deep; // Aligned deep entry opcode
   logic hit_res; // Aligned resume opcode
   logic hit_ule; // Aligned ultra entry opcode
   assign hit_deep = good_cmd(op_r, bits_r, byte_r, `PD_OP_DEEP);
   assign hit_res = good_cmd(op_r, bits_r, byte_r, `PD_OP_RESUME);
   assign hit_ule = good_cmd(op_r, bits_r, byte_r, `PD_OP_ULTRA);

   ////////////////////////////////////////////////////////////
   // Frame ownership
   // Frames begun during a timed transition are void, so an early
   // frame cannot be decoded once the timer has expired
   logic live_r; // Frame began in standby or deep
   logic uframe_r; // Frame began in ultra

   pd_state_e state_r;
   logic [TMR_W-1:0] tmr_r;

   // Tag each frame by the state at its start
   always_ff @(posedge clock) begin
      if (!nrst) begin
         live_r <= 1'b0;
         uframe_r <= 1'b0;
      end else if (cs_fall) begin
         live_r <= (state_r == ST_STANDBY) || (state_r == ST_DEEP);
         uframe_r <= (state_r == ST_ULTRA);
      end else if (cs_rise) begin
         live_r <= 1'b0;
         uframe_r <= 1'b0;
      end
   end

   logic done; // Frame just closed with a live tag
   assign done = cs_rise & live_r;

   ////////////////////////////////////////////////////////////
   // Power state machine and transition timer
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_r <= ST_STANDBY;
         tmr_r <= '0;
      end else begin
         case (state_r)
            ST_STANDBY: begin
               // Busy program or erase drops both entries
               if (done && hit_deep && !busy) begin
                  state_r <= ST_DEEP_ENTRY;
                  tmr_r <= TMR_W'(DEEP_CYC - 1);
               end else if (done && hit_ule && !busy) begin
                  state_r <= ST_ULTRA_ENTRY;
                  tmr_r <= TMR_W'(ULE_CYC - 1);
               end
            end
            ST_DEEP: begin
               // Only resume is recognised here
               if (done && hit_res) begin
                  state_r <= ST_RESUME;
                  tmr_r <= TMR_W'(RES_CYC - 1);
               end
            end
            ST_ULTRA: begin
               // Any pulse exits, dummy byte or not
               if (cs_rise && uframe_r) begin
                  state_r <= ST_ULTRA_EXIT;
                  tmr_r <= TMR_W'(ULX_CYC - 1);
               end
            end
            ST_DEEP_ENTRY, ST_RESUME, ST_ULTRA_ENTRY, ST_ULTRA_EXIT: begin
               if (tmr_r != '0) begin
                  tmr_r <= tmr_r - 1'b1;
               end else begin
                  case (state_r)
                     ST_DEEP_ENTRY: state_r <= ST_DEEP;
                     ST_ULTRA_ENTRY: state_r <= ST_ULTRA;
                     default: state_r <= ST_STANDBY;
                  endcase
               end
            end
            default: begin
               state_r <= ST_STANDBY;
               tmr_r <= '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // Status outputs
   logic ule_go; // Ultra entry accepted this cycle
   assign ule_go = (state_r == ST_STANDBY) && done && hit_ule && !busy && !hit_deep;

   // Registered so the outputs come straight from flops
   always_ff @(posedge clock) begin
      if (!nrst) begin
         status <= 4'b0000;
      end else begin
         status.standby <= (state_r == ST_STANDBY) && sync_r.cs_n && !busy;
         status.deep <= (state_r == ST_DEEP);
         status.ultra <= (state_r == ST_ULTRA);
         status.cmd_ok <= (state_r == ST_STANDBY);
      end
   end

   // One pulse tells the buffers their contents are gone
   always_ff @(posedge clock) begin
      if (!nrst) begin
         buf_discard <= 1'b0;
      end else begin
         buf_discard <= ule_go;
      end
   end

   ////////////////////////////////////////////////////////////
   // Checks
   // Cycles spent waiting in ultra exit; the bound is too long for a
   // delay range, so a counter carries it instead
   logic [TMR_W-1:0] ulx_age_r;

   // Age restarts whenever the exit wait is not running
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ulx_age_r <= '0;
      end else if (state_r == ST_ULTRA_EXIT) begin
         ulx_age_r <= ulx_age_r + 1'b1;
      end else begin
         ulx_age_r <= '0;
      end
   end

   sequence deep_req;
      (state_r == ST_STANDBY) && done && hit_deep && !busy;
   endsequence
   sequence ule_req;
      (state_r == ST_STANDBY) && done && hit_ule && !busy;
   endsequence
   sequence res_req;
      (state_r == ST_DEEP) && done && hit_res;
   endsequence
   sequence ulx_req;
      (state_r == ST_ULTRA) && cs_rise && uframe_r;
   endsequence
   sequence late_frame;
      cs_fall && (state_r != ST_STANDBY) && (state_r != ST_DEEP);
   endsequence

   chk_deep_entry: assert property (@(posedge clock) disable iff (!nrst)
      deep_req |=> (state_r == ST_DEEP_ENTRY) ##[1:DEEP_WIN] (state_r == ST_DEEP))
      else $error("deep entry late");
   chk_ultra_entry: assert property (@(posedge clock) disable iff (!nrst)
      ule_req |=> (state_r == ST_ULTRA_ENTRY) ##[1:ULE_WIN] (state_r == ST_ULTRA))
      else $error("ultra entry late");
   chk_resume_time: assert property (@(posedge clock) disable iff (!nrst)
      res_req |=> ##[1:RES_WIN] (state_r == ST_STANDBY))
      else $error("resume late");
   chk_ultra_exit: assert property (@(posedge clock) disable iff (!nrst)
      ulx_req |=> (state_r == ST_ULTRA_EXIT) [*2])
      else $error("ultra exit not started");
   chk_exit_bound: assert property (@(posedge clock) disable iff (!nrst)
      (state_r == ST_ULTRA_EXIT) |-> (ulx_age_r < ULX_WIN))
      else $error("ultra exit late");
   chk_exit_lands: assert property (@(posedge clock) disable iff (!nrst)
      (state_r == ST_ULTRA_EXIT) |=> (state_r == ST_ULTRA_EXIT) || (state_r == ST_STANDBY))
      else $error("ultra exit left for wrong state");
   chk_busy_drop: assert property (@(posedge clock) disable iff (!nrst)
      (state_r == ST_STANDBY) && busy |=> (state_r == ST_STANDBY))
      else $error("entry taken while busy");
   chk_deep_hold: assert property (@(posedge clock) disable iff (!nrst)
      (state_r == ST_DEEP) && !(done && hit_res) |=> (state_r == ST_DEEP))
      else $error("deep left without resume");
   chk_resume_abort: assert property (@(posedge clock) disable iff (!nrst)
      (state_r == ST_DEEP) && done && !(byte_r && bits_r == 3'h0) |=> (state_r == ST_DEEP))
      else $error("misaligned resume taken");
   chk_ultra_hold: assert property (@(posedge clock) disable iff (!nrst)
      (state_r == ST_ULTRA) && !cs_rise |=> (state_r == ST_ULTRA))
      else $error("ultra left without pulse");
   chk_entry_abort: assert property (@(posedge clock) disable iff (!nrst)
      (state_r == ST_STANDBY) && done && (bits_r != 3'h0) |=> (state_r == ST_STANDBY))
      else $error("misaligned entry taken");
   chk_buf_discard: assert property (@(posedge clock) disable iff (!nrst)
      ule_req |=> buf_discard ##1 !buf_discard)
      else $error("buffer discard missing");
   chk_standby_flag: assert property (@(posedge clock) disable iff (!nrst)
      status.standby |-> ($past(state_r) == ST_STANDBY) && $past(sync_r.cs_n) && !$past(busy))
      else $error("standby flag wrong");
   chk_trail_ignored: assert property (@(posedge clock) disable iff (!nrst)
      sck_rise && byte_r |=> $stable(op_r))
      else $error("opcode changed after first byte");
   chk_discard_only: assert property (@(posedge clock) disable iff (!nrst)
      buf_discard |-> (state_r == ST_ULTRA_ENTRY))
      else $error("buffer discard outside ultra entry");
   chk_cmd_gate: assert property (@(posedge clock) disable iff (!nrst)
      status.cmd_ok |-> !status.deep && !status.ultra)
      else $error("commands open while powered down");
   chk_entry_lands: assert property (@(posedge clock) disable iff (!nrst)
      (state_r == ST_DEEP_ENTRY) |=> (state_r == ST_DEEP_ENTRY) || (state_r == ST_DEEP))
      else $error("deep entry left for wrong state");
   chk_resume_lands: assert property (@(posedge clock) disable iff (!nrst)
      (state_r == ST_RESUME) |=> (state_r == ST_RESUME) || (state_r == ST_STANDBY))
      else $error("resume left for wrong state");
   chk_void_frame: assert property (@(posedge clock) disable iff (!nrst)
      late_frame |=> !live_r)
      else $error("frame begun in transition kept");

endmodule : spi_flash_power_down_control
`default_nettype wire

// file: verification/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Behavioural serial host in mode 0 or mode 3; the link clock stands still between frames
module spi_host_model (
   input wire logic clock,
   output logic cs_n,
   output logic sck,
   output logic si
);
   // Idle levels at time zero
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // Wait whole system clock edges, so every change lands just after an edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick
   // One frame, bits taken from the top of data; half period of four clocks.
   // Mode 3 parks the clock high before select falls and drops it after release
   task automatic frame(input logic [15:0] data, input int nbits, input bit mode3 = 1'b0);
      if (mode3) begin
         sck <= 1'b1;
         tick(4);
      end
      cs_n <= 1'b0;
      si <= data[15];
      tick(4);
      for (int i = 0; i < nbits; i++) begin
         if (mode3) begin
            sck <= 1'b0;
            if (i > 0 && i < 16) si <= data[15-i];
            tick(4);
         end
         sck <= 1'b1;
         tick(4);
         if (!mode3) begin
            sck <= 1'b0;
            if (i < 15) si <= data[14-i];
            tick(4);
         end
      end
      cs_n <= 1'b1;
      // Released data line must not keep the last bit alive
      si <= ~si;
      tick(3);
      sck <= 1'b0;
      tick(3);
   endtask : frame
   // Bare select pulse with no serial clock
   task automatic pulse(input int low);
      cs_n <= 1'b0;
      tick(low);
      cs_n <= 1'b1;
      tick(6);
   endtask : pulse
endmodule : spi_host_model
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "pd_map.svh"
////////////////////////////////////////////////////////////////////////////////
module testbench;
   import pd_pkg::*;
   logic clock; // System clock
   logic nrst; // Reset, active low
   logic busy; // Program or erase running
   logic sample_req; // Asks the monitor to compare
   logic cs_n, sck, si; // Pins from the host model
   pd_status_s status;
   logic buf_discard;
   int error_cnt, checks_done, disc_cnt;
   logic [3:0] exp_q[$]; // Expected status notes
   string name_q[$];
   // Clock at 25 MHz
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   spi_flash_power_down_control u_spi_flash_power_down_control (.clock(clock), .nrst(nrst), .cs_n(cs_n),
      .sck(sck), .si(si), .busy(busy), .status(status), .buf_discard(buf_discard));
   spi_host_model u_spi_host_model (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Wait, then leave a note for the monitor; wait_n is at least one
   task automatic note(input string what, input logic [3:0] exp, input int wait_n);
      u_spi_host_model.tick(wait_n);
      name_q.push_back(what);
      exp_q.push_back(exp);
      sample_req <= 1'b1;
      @(posedge clock);
      sample_req <= 1'b0;
   endtask : note
   task automatic end_of_test();
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // Monitor compares at the falling edge, where outputs have settled
   always @(negedge clock) begin
      if (sample_req === 1'b1) check(name_q.pop_front(), status, exp_q.pop_front());
      if (buf_discard === 1'b1) disc_cnt++;
   end
   // Watchdog well past the expected run of about 9000 cycles
   initial begin
      #(40 * 40000);
      error_cnt++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] ab_op[4];
      int ab_n[4];
      logic [7:0] dp_op[4];
      int dp_n[4];
      logic [7:0] r;
      ab_op = '{`PD_OP_DEEP, `PD_OP_DEEP, `PD_OP_ULTRA, `PD_OP_ULTRA};
      ab_n = '{7, 11, 12, 5};
      nrst = 1'b0;
      busy = 1'b0;
      sample_req = 1'b0;
      error_cnt = 0;
      checks_done = 0;
      disc_cnt = 0;
      void'($urandom(51990));
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      note("reset", 4'b1001, 6);
      busy <= 1'b1;
      note("busy", 4'b0001, 3);
      u_spi_host_model.frame({`PD_OP_DEEP, 8'h00}, 8);
      note("deep_busy", 4'b0001, 100);
      u_spi_host_model.frame({`PD_OP_ULTRA, 8'h00}, 8);
      note("ultra_busy", 4'b0001, 100);
      busy <= 1'b0;
      // Short and misaligned entries abort
      for (int i = 0; i < 4; i++) begin
         u_spi_host_model.frame({ab_op[i], 8'($urandom)}, ab_n[i]);
         note("abort", 4'b1001, 100);
      end
      u_spi_host_model.frame({`PD_OP_DEEP, 8'($urandom)}, 16, 1'b1);
      note("deep", 4'b0100, 100);
      // Everything but an aligned resume is ignored in deep
      r = 8'($urandom);
      if (r == `PD_OP_RESUME) r = r ^ 8'h01;
      dp_op = '{`PD_OP_ULTRA, r, `PD_OP_RESUME, `PD_OP_RESUME};
      dp_n = '{8, 16, 6, 10};
      for (int i = 0; i < 4; i++) begin
         u_spi_host_model.frame({dp_op[i], 8'($urandom)}, dp_n[i]);
         note("deep_hold", 4'b0100, 100);
      end
      u_spi_host_model.frame({`PD_OP_RESUME, 8'($urandom)}, 16, 1'b1);
      note("resume", 4'b1001, 900);
      u_spi_host_model.frame({`PD_OP_ULTRA, 8'h00}, 8);
      note("ultra", 4'b0010, 100);
      check("discard", disc_cnt[3:0], 4'h1);
      // Exit with a dummy resume byte, then a deep entry inside the exit time
      u_spi_host_model.frame({`PD_OP_RESUME, 8'h00}, 8);
      u_spi_host_model.frame({`PD_OP_DEEP, 8'h00}, 8);
      note("ultra_exit", 4'b1001, 2520);
      u_spi_host_model.frame({`PD_OP_ULTRA, 8'h00}, 8);
      note("ultra_again", 4'b0010, 100);
      u_spi_host_model.pulse(5);
      note("pulse_exit", 4'b1001, 2520);
      check("discard_two", disc_cnt[3:0], 4'h2);
      // Reset in mid-run from deep must land in standby
      u_spi_host_model.frame({`PD_OP_DEEP, 8'($urandom)}, 8);
      note("deep_again", 4'b0100, 100);
      nrst <= 1'b0;
      u_spi_host_model.tick(2);
      nrst <= 1'b1;
      note("reset_again", 4'b1001, 6);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
